// File: core/dapr_pkg.sv
// constants shared by the dual converter readout block
package dapr_pkg;

  // result word width and result buffer depth
  localparam int unsigned RESULT_WIDTH = 14;
  localparam int unsigned BUFFER_DEPTH = 2;

  // clock period and the interval from conversion start to the end of hold
  localparam int unsigned CLOCK_PERIOD_PS = 40000;
  localparam int unsigned CONVERSION_TIME_NS = 5200;
  localparam int unsigned CONVERSION_CYCLES =
    (CONVERSION_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // counter width for the conversion interval
  localparam int unsigned CONV_COUNT_WIDTH = 8;

  // pair select levels
  localparam logic PAIR_SELECT_A = 1'b0;
  localparam logic PAIR_SELECT_B = 1'b1;

  // reset values
  localparam logic [13:0] RESULT_RESET = 14'h0000;
  localparam logic        BUSY_RESET = 1'b0;
  localparam logic        POWER_DOWN_RESET = 1'b1;
  localparam logic        HOLD_RESET = 1'b0;

  // sequencer states, one-hot
  typedef enum logic [3:0]
  {
    DAPR_ST_SLEEP  = 4'b0001,
    DAPR_ST_CONV   = 4'b0010,
    DAPR_ST_FIRST  = 4'b0100,
    DAPR_ST_SECOND = 4'b1000
  } dapr_state_e;

endpackage

// File: core/dapr_top.sv
// dual simultaneous-sampling converter control and parallel readout
`timescale 1ns/1ps

// Functional notes
// - a start request holds both channels and starts both conversions together
// - busy falling marks the end of conversion with both results readable
// - results become available 132 cycles (5.28 us) after the start request, later if the buffer is full
// - four inputs form pairs A and B; each pair is sampled together
// - first read after a conversion returns the first input of the pair
// - second read after a conversion returns the second input of the pair
// - pair select low chooses pair A, high chooses pair B
// - results are read over a 14-bit bus qualified by chip-select and read
// - power down after each conversion, wake up at the next start request
module dapr_top #(
  parameter int unsigned WIDTH = dapr_pkg::RESULT_WIDTH,
  parameter int unsigned DEPTH = dapr_pkg::BUFFER_DEPTH
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_conversion_start_n,
  input  wire logic             i_pair_select,
  input  wire logic             i_cs_n,
  input  wire logic             i_rd_n,
  input  wire logic [WIDTH-1:0] i_pair_a_first_input,
  input  wire logic [WIDTH-1:0] i_pair_a_second_input,
  input  wire logic [WIDTH-1:0] i_pair_b_first_input,
  input  wire logic [WIDTH-1:0] i_pair_b_second_input,
  input  wire logic [WIDTH-1:0] i_data_in,
  output logic                  o_busy,
  output logic                  o_hold,
  output logic                  o_power_down,
  output logic [WIDTH-1:0]      o_data_out,
  output logic                  o_data_oe
);

  localparam int unsigned PTR_WIDTH = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_WIDTH = $clog2(DEPTH + 1);
  localparam logic [dapr_pkg::CONV_COUNT_WIDTH-1:0] CONV_LAST =
    dapr_pkg::CONV_COUNT_WIDTH'(dapr_pkg::CONVERSION_CYCLES - 1);

  // elaboration checks
  if (WIDTH != dapr_pkg::RESULT_WIDTH)
  begin : g_bad_width
    $error("result width must match the converter resolution");
  end
  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0))
  begin : g_bad_depth
    $error("buffer depth must be a power of two of at least two");
  end
  if (dapr_pkg::CONVERSION_CYCLES >= (1 << dapr_pkg::CONV_COUNT_WIDTH))
  begin : g_bad_count
    $error("conversion counter too narrow");
  end

  // pointer advance with wrap
  function automatic logic [PTR_WIDTH-1:0] ptr_step(input logic [PTR_WIDTH-1:0] ptr);
    ptr_step = (ptr == PTR_WIDTH'(DEPTH - 1)) ? '0 : ptr + 1'b1;
  endfunction

  dapr_pkg::dapr_state_e state_reg;
  dapr_pkg::dapr_state_e state_next;

  logic [dapr_pkg::CONV_COUNT_WIDTH-1:0] conv_count_reg;
  logic                                  start_prev_reg;
  logic                                  rd_prev_reg;
  logic [WIDTH-1:0]                      first_sample_reg;
  logic [WIDTH-1:0]                      second_sample_reg;
  logic                                  busy_reg;
  logic                                  hold_reg;
  logic                                  power_down_reg;
  logic [WIDTH-1:0]                      data_reg;
  logic                                  oe_reg;

  logic [WIDTH-1:0]     buf_mem [DEPTH];
  logic [PTR_WIDTH-1:0] wr_ptr_reg;
  logic [PTR_WIDTH-1:0] rd_ptr_reg;
  logic [CNT_WIDTH-1:0] fill_reg;

  logic             start_req;
  logic             read_req;
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic             push_fire;
  logic             pop_fire;

  // falling edge of start and of a qualified read strobe
  assign start_req = start_prev_reg && !i_conversion_start_n;
  assign read_req = rd_prev_reg && !i_rd_n && !i_cs_n;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
    end
    else
    begin
      start_prev_reg <= i_conversion_start_n;
      rd_prev_reg <= i_rd_n;
    end
  end

  // buffer handshake
  assign push_ready = (fill_reg != CNT_WIDTH'(DEPTH));
  assign pop_valid = (fill_reg != '0);
  assign pop_ready = read_req;
  assign push_fire = push_valid && push_ready;
  assign pop_fire = pop_valid && pop_ready;

  // sequencer: sleep, convert, then push the two results in order
  always_comb
  begin
    state_next = state_reg;
    push_valid = 1'b0;
    push_data = first_sample_reg;
    unique case (state_reg)
      dapr_pkg::DAPR_ST_SLEEP:
      begin
        if (start_req)
        begin
          state_next = dapr_pkg::DAPR_ST_CONV;
        end
      end
      dapr_pkg::DAPR_ST_CONV:
      begin
        if (conv_count_reg == CONV_LAST)
        begin
          state_next = dapr_pkg::DAPR_ST_FIRST;
        end
      end
      dapr_pkg::DAPR_ST_FIRST:
      begin
        push_valid = 1'b1;
        push_data = first_sample_reg;
        if (push_ready)
        begin
          state_next = dapr_pkg::DAPR_ST_SECOND;
        end
      end
      dapr_pkg::DAPR_ST_SECOND:
      begin
        push_valid = 1'b1;
        push_data = second_sample_reg;
        if (push_ready)
        begin
          state_next = dapr_pkg::DAPR_ST_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= dapr_pkg::DAPR_ST_SLEEP;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // conversion interval counter
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      conv_count_reg <= '0;
    end
    else if (state_reg == dapr_pkg::DAPR_ST_CONV)
    begin
      conv_count_reg <= conv_count_reg + 1'b1;
    end
    else
    begin
      conv_count_reg <= '0;
    end
  end

  // both channels of the selected pair captured on the same edge
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      first_sample_reg <= dapr_pkg::RESULT_RESET;
      second_sample_reg <= dapr_pkg::RESULT_RESET;
    end
    else if ((state_reg == dapr_pkg::DAPR_ST_SLEEP) && start_req)
    begin
      if (i_pair_select == dapr_pkg::PAIR_SELECT_B)
      begin
        first_sample_reg <= i_pair_b_first_input;
        second_sample_reg <= i_pair_b_second_input;
      end
      else
      begin
        first_sample_reg <= i_pair_a_first_input;
        second_sample_reg <= i_pair_a_second_input;
      end
    end
  end

  // hold, busy and power-down status
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_reg <= dapr_pkg::HOLD_RESET;
      busy_reg <= dapr_pkg::BUSY_RESET;
      power_down_reg <= dapr_pkg::POWER_DOWN_RESET;
    end
    else
    begin
      hold_reg <= (state_next == dapr_pkg::DAPR_ST_CONV);
      busy_reg <= (state_next != dapr_pkg::DAPR_ST_SLEEP);
      power_down_reg <= (state_next == dapr_pkg::DAPR_ST_SLEEP);
    end
  end

  // two-entry result buffer
  always_ff @(posedge i_clock)
  begin
    if (push_fire)
    begin
      buf_mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end
    else
    begin
      if (push_fire)
      begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (pop_fire)
      begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      if (push_fire && !pop_fire)
      begin
        fill_reg <= fill_reg + 1'b1;
      end
      else if (pop_fire && !push_fire)
      begin
        fill_reg <= fill_reg - 1'b1;
      end
    end
  end

  // read port: a qualified strobe takes the oldest result
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      data_reg <= dapr_pkg::RESULT_RESET;
    end
    else if (pop_fire)
    begin
      data_reg <= buf_mem[rd_ptr_reg];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      oe_reg <= 1'b0;
    end
    else
    begin
      oe_reg <= !i_cs_n && !i_rd_n;
    end
  end

  assign o_busy = busy_reg;
  assign o_hold = hold_reg;
  assign o_power_down = power_down_reg;
  assign o_data_out = data_reg;
  assign o_data_oe = oe_reg;

endmodule

// File: test/dapr_monitor.sv
// checker for the readout block ports
`timescale 1ns/1ps
module dapr_monitor #(
  parameter int unsigned WIDTH = 14
)(
  input wire logic             i_clock,
  input wire logic             i_rst,
  input wire logic             i_conversion_start_n,
  input wire logic             i_cs_n,
  input wire logic             i_rd_n,
  input wire logic             o_busy,
  input wire logic             o_hold,
  input wire logic             o_power_down,
  input wire logic [WIDTH-1:0] o_data_out,
  input wire logic             o_data_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_start_holds_both: assert property (!o_busy && $past(i_conversion_start_n) &&
    !i_conversion_start_n |=> o_busy && o_hold && !o_power_down) else $error("start ignored");
  a_hold_same_time: assert property ($rose(o_hold) |-> $rose(o_busy))
    else $error("hold without busy");
  a_hold_length: assert property ($rose(o_hold) |-> ##129 o_hold ##1 !o_hold)
    else $error("hold length wrong");
  a_busy_length: assert property ($rose(o_busy) |-> ##131 o_busy)
    else $error("busy ended early");
  a_busy_end_ready: assert property ($fell(o_busy) |-> !o_hold && !$past(o_hold, 2))
    else $error("busy ended during hold");
  a_power_down_idle: assert property ($fell(o_busy) |-> o_power_down)
    else $error("no power down");
  a_awake_busy: assert property (o_busy |-> !o_power_down)
    else $error("asleep while busy");
  a_drive_strobes: assert property (o_data_oe == (!$past(i_cs_n) && !$past(i_rd_n)))
    else $error("drive enable wrong");
  a_data_steady: assert property (!($past(i_rd_n) && !i_rd_n && !i_cs_n)
    |=> $stable(o_data_out)) else $error("data changed without read");
endmodule
bind dapr_top dapr_monitor #(.WIDTH(WIDTH)) u_mon (.i_clock(i_clock), .i_rst(i_rst),
  .i_conversion_start_n(i_conversion_start_n), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
  .o_busy(o_busy), .o_hold(o_hold), .o_power_down(o_power_down),
  .o_data_out(o_data_out), .o_data_oe(o_data_oe));

// File: test/dapr_host_model.sv
// host bus model: start requests and strobed reads
`timescale 1ns/1ps
module dapr_host_model (
  input  wire logic        i_clock,
  input  wire logic [13:0] i_data,
  input  wire logic        i_oe,
  output logic             o_start_n = 1'b1,
  output logic             o_select = 1'b0,
  output logic             o_cs_n = 1'b1,
  output logic             o_rd_n = 1'b1
);
  task automatic start(input logic s);
    @(negedge i_clock);
    o_select = s;
    o_start_n = 1'b0;
    @(negedge i_clock);
    o_start_n = 1'b1;
  endtask
  task automatic read(output logic [13:0] w);
    @(negedge i_clock);
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    @(negedge i_clock);
    w = (i_oe === 1'b1) ? i_data : ~i_data;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
  endtask
endmodule

// File: test/dual_adc_parallel_readout_tb.sv
// self-checking bench for the readout block
`timescale 1ns/1ps
module dual_adc_parallel_readout_tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] a1 = 14'h1A2B;
  logic [13:0] a2 = 14'h0C3D;
  logic [13:0] b1 = 14'h2E4F;
  logic [13:0] b2 = 14'h3150;
  logic        start_n, sel, cs_n, rd_n, busy, hold, pd, oe;
  logic [13:0] data, w;
  int          err_total = 0;
  int          checks = 0;
  always #20 clock = ~clock;
  dapr_top DUT (.i_clock(clock), .i_rst(rst), .i_conversion_start_n(start_n),
    .i_pair_select(sel), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_pair_a_first_input(a1),
    .i_pair_a_second_input(a2), .i_pair_b_first_input(b1), .i_pair_b_second_input(b2),
    .i_data_in(14'h0000), .o_busy(busy), .o_hold(hold), .o_power_down(pd),
    .o_data_out(data), .o_data_oe(oe));
  dapr_host_model host (.i_clock(clock), .i_data(data), .i_oe(oe), .o_start_n(start_n),
    .o_select(sel), .o_cs_n(cs_n), .o_rd_n(rd_n));
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1 && n < 400)
    begin
      n++;
      @(negedge clock);
    end
  endtask
  task automatic t_pair_a;
    int n;
    host.start(1'b0);
    wait_idle(n);
    chk("busy cycles", 14'h084, 14'(n));
    chk("power down", 14'h0001, {13'h0, pd});
    host.read(w);
    chk("first a", a1, w);
    @(negedge clock);
    chk("drive idle", 14'h0000, {13'h0, oe});
    host.read(w);
    chk("second a", a2, w);
  endtask
  task automatic t_pair_b;
    int n;
    host.start(1'b1);
    wait_idle(n);
    chk("busy cycles b", 14'h084, 14'(n));
    host.read(w);
    chk("first b", b1, w);
    host.read(w);
    chk("second b", b2, w);
  endtask
  task automatic t_stall;
    int n;
    host.start(1'b0);
    wait_idle(n);
    host.start(1'b1);
    repeat (150) @(negedge clock);
    chk("stalled busy", 14'h0001, {13'h0, busy});
    host.read(w);
    chk("held a", a1, w);
    host.read(w);
    chk("held a second", a2, w);
    wait_idle(n);
    chk("busy released", 14'h0000, {13'h0, busy});
    host.read(w);
    chk("late b", b1, w);
    host.read(w);
    chk("late b second", b2, w);
    host.read(w);
    chk("empty read", b2, w);
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_pair_a();
    t_pair_b();
    t_stall();
    summarize();
  end
  initial
  begin
    #80000;
    err_total++;
    summarize();
  end
endmodule
